// ==== verilog/etfc_map.svh ====
/*
 * register indices, field positions, reset values and frame figures
 * for the test and frame-format control block.
 * assumes: included by bare name from the module and the bench.
 */
`ifndef ETFC_MAP_SVH
`define ETFC_MAP_SVH
// register indices, byte address is four times the index
`define ETFC_IDX_TEST 8'h20
`define ETFC_IDX_CFG1 8'h21
`define ETFC_IDX_STAT 8'h28
// reset values
`define ETFC_TEST_RST 8'h00
`define ETFC_CFG1_RST 8'h00
`define ETFC_STAT_RST 8'h00
// writable bits of the test register, top bit reserved
`define ETFC_TEST_WMASK 8'h7F
// test register fields
`define ETFC_T_FIFO 6
`define ETFC_T_DIR 5
`define ETFC_T_SST 4
`define ETFC_T_SIM 3
`define ETFC_T_FOVR 2
`define ETFC_T_FUND 1
`define ETFC_T_LOOPBACK_ENABLE 0
// frame config fields
`define ETFC_C_PAD 7
`define ETFC_C_VAD 6
`define ETFC_C_P64 5
`define ETFC_C_FCS 4
`define ETFC_C_FULL 3
`define ETFC_C_LCHK 2
`define ETFC_C_UNB 1
`define ETFC_C_HDR 0
// status fields, write one to clear
`define ETFC_S_ROVR 0
`define ETFC_S_TUND 1
`define ETFC_S_TLEN 2
`define ETFC_S_RLEN 3
`define ETFC_S_RLONG 4
`define ETFC_STAT_MASK 8'h1F
// frame figures in bytes
`define ETFC_PAD_MIN 11'h03C
`define ETFC_PAD_VLAN 11'h040
`define ETFC_VLAN_TPID 16'h8100
`define ETFC_LEN_MAX 16'h05DC
`define ETFC_DATA_MIN 16'h002E
`define ETFC_HDR_LEN 11'h004
`define ETFC_ETH_HDR 16'h000E
`define ETFC_FCS_LEN 16'h0004
// frame check sequence
`define ETFC_CRC_INIT 32'hFFFFFFFF
`define ETFC_CRC_POLY 32'hEDB88320
`endif

// ==== verilog/etfc_pkg.sv ====
/*
 * types shared by the test and frame-format control block.
 * assumes: nothing beyond the map header.
 */
package etfc_pkg;
	// one byte of a frame stream with its end mark
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} etfc_byte_s;
	// one received byte towards the receive fifo
	typedef struct packed {
		logic [7:0] data;
		logic last;
		logic err;
	} etfc_rxb_s;
	// transmit framer states
	typedef enum logic [1:0] {
		TX_IDLE,
		TX_DATA,
		TX_PAD,
		TX_FCS
	} etfc_txst_e;
endpackage

// ==== verilog/etfc_top.sv ====
/*
 * test controls and frame-format configuration of the ethernet mac:
 * ahb-lite register slave, transmit framer with pad and fcs, receive
 * path with loopback, overrun discard and length checks.
 * assumes: phy receive pins arrive asynchronous, all else on hclk.
 */
// Added by the designer: the AHB-Lite interface to the registers.
// Function
// - rx packet event regardless of cpu halt
// - reset restores all register defaults
// - unused locations ignore writes, read zero
// - test bit 7 reserved, reads zero
// - test bit 6 selects fifo test mode
// - test bit 5 picks rx or tx fifo
// - test bit 4 shortens slot timer
// - test bit 3 applies simulation reset
// - test bit 2 forces rx overrun
// - test bit 1 forces tx underrun
// - test bit 0 loops tx into rx
// - pad enable extends short frames with zeros
// - vlan autodetect compares type with 8100
// - plain padding gives 60 plus fcs
// - pad_to_64 gives 64 plus fcs
// - autodetect pads 60 or 64 by tag
// - fcs appended when enabled or when padding, none otherwise
// - bit 3 full duplex disables csma/cd
// - bit 2 checks length field against frame
// - bit 1 lifts receive max frame limit
// - bit 0 skips four-byte header in fcs
// - after overrun drop packets until cleared
`include "etfc_map.svh"
module etfc_top import etfc_pkg::*; (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// transmit bytes from the tx fifo
	input wire logic tx_in_valid,
	input wire etfc_byte_s tx_in,
	output logic tx_in_ready,
	// transmit bytes towards the phy
	output logic tx_out_valid,
	output etfc_byte_s tx_out,
	input wire logic tx_out_ready,
	// receive pins from the phy
	input wire logic rx_pin_valid,
	input wire etfc_byte_s rx_pin,
	// receive bytes into the rx fifo
	output logic rx_out_valid,
	output etfc_rxb_s rx_out,
	input wire logic rx_fifo_ready,
	output logic rx_packet_event,
	// receive size limit
	input wire logic [15:0] max_frame_length,
	// mode levels for the rest of the mac
	output logic fifo_test_mode,
	output logic fifo_direction_select,
	output logic slot_timer_shortcut,
	output logic simulation_reset,
	output logic duplex_full,
	output logic csma_cd_enable,
	output logic length_field_check,
	output logic unbounded_frame_enable
);

	// crc-32 over one byte, lsb first
	function automatic logic [31:0] crc_step(input logic [31:0] c,
		input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[0] ^ d[i]) begin
				r = (r >> 1) ^ `ETFC_CRC_POLY;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction

	// byte address of a register index
	function automatic logic [7:0] reg_addr(input logic [7:0] idx);
		return {idx[5:0], 2'b00};
	endfunction

	// length field present and disagreeing with the data length
	function automatic logic len_bad(input logic [15:0] f,
		input logic [15:0] d);
		return (f <= `ETFC_LEN_MAX) &&
			((d < f) || ((d > f) && (d > `ETFC_DATA_MIN)));
	endfunction

	// registers
	logic [7:0] test_r; // test controls
	logic [7:0] cfg_r; // frame format controls
	logic [7:0] stat_r; // sticky event flags
	logic [7:0] stat_set; // events this cycle
	// bus state
	logic wr_pend_r; // write data phase
	logic rd_pend_r; // read wait cycle
	logic [7:0] addr_r; // latched byte address
	logic [31:0] hrdata_r; // read data
	wire ap = hsel && htrans[1] && hready;
	wire sel_test = addr_r == reg_addr(`ETFC_IDX_TEST);
	wire sel_cfg = addr_r == reg_addr(`ETFC_IDX_CFG1);
	wire sel_stat = addr_r == reg_addr(`ETFC_IDX_STAT);
	wire [31:0] rd_mux = sel_test ? {24'h000000, test_r} :
		sel_cfg ? {24'h000000, cfg_r} :
		sel_stat ? {24'h000000, stat_r} : 32'h00000000;
	wire [7:0] stat_clr = (wr_pend_r && sel_stat) ?
		hwdata[7:0] : 8'h00;
	// control decode
	wire sim_rst = test_r[`ETFC_T_SIM];
	wire loopback_enable = test_r[`ETFC_T_LOOPBACK_ENABLE];
	wire pad_en = cfg_r[`ETFC_C_PAD];
	wire fcs_en = cfg_r[`ETFC_C_FCS] || pad_en;
	wire [10:0] hdr = cfg_r[`ETFC_C_HDR] ? `ETFC_HDR_LEN : 11'h000;

	// address phase capture; reads take one wait cycle so that a
	// write just before is already visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 8'h00;
		end else begin
			wr_pend_r <= ap && hwrite;
			rd_pend_r <= ap && !hwrite;
			if (ap) begin
				addr_r <= haddr[7:0];
			end
		end
	end

	// read data loaded during the wait cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h00000000;
		end else if (rd_pend_r) begin
			hrdata_r <= rd_mux;
		end
	end

	// register writes; reserved and unused bits dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			test_r <= `ETFC_TEST_RST;
			cfg_r <= `ETFC_CFG1_RST;
			stat_r <= `ETFC_STAT_RST;
		end else begin
			if (wr_pend_r && sel_test) begin
				test_r <= hwdata[7:0] & `ETFC_TEST_WMASK;
			end
			if (wr_pend_r && sel_cfg) begin
				cfg_r <= hwdata[7:0];
			end
			// set wins over a clear in the same cycle
			stat_r <= ((stat_r & ~stat_clr) | stat_set) & `ETFC_STAT_MASK;
		end
	end

	assign hreadyout = !rd_pend_r;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	// mode levels straight from the registers
	assign fifo_test_mode = test_r[`ETFC_T_FIFO];
	assign fifo_direction_select = test_r[`ETFC_T_DIR];
	assign slot_timer_shortcut = test_r[`ETFC_T_SST];
	assign simulation_reset = sim_rst;
	assign duplex_full = cfg_r[`ETFC_C_FULL];
	assign csma_cd_enable = !cfg_r[`ETFC_C_FULL];
	assign length_field_check = cfg_r[`ETFC_C_LCHK];
	assign unbounded_frame_enable = cfg_r[`ETFC_C_UNB];

	// transmit framer
	etfc_txst_e tx_st_r; // framer state
	logic [10:0] pos_r; // bytes sent this frame, header included
	logic [31:0] crc_r; // running crc
	logic [1:0] fcnt_r; // fcs byte index
	logic [7:0] type_hi_r; // first length/type byte
	logic [15:0] type_r; // full length/type field
	logic vlan_r; // frame carries a vlan tag
	logic out_v_r; // output byte held
	etfc_byte_s out_r; // output byte
	wire adv = !out_v_r || tx_out_ready;
	wire fire = tx_out_valid && tx_out_ready;
	wire [10:0] bidx = pos_r - hdr;
	wire in_body = pos_r >= hdr;
	wire vlan_now = (bidx == 11'd13) && in_body &&
		({type_hi_r, tx_in.data} == `ETFC_VLAN_TPID);
	// pad target chosen by the autodetect and fixed-64 controls
	wire [10:0] pad_tgt = cfg_r[`ETFC_C_VAD] ?
		((vlan_r || vlan_now) ? `ETFC_PAD_VLAN : `ETFC_PAD_MIN) :
		(cfg_r[`ETFC_C_P64] ? `ETFC_PAD_VLAN : `ETFC_PAD_MIN);
	wire take = tx_in_valid && tx_in_ready;
	wire need_pad = pad_en && ((bidx + 11'd1) < pad_tgt);
	wire [31:0] fcs = ~crc_r;
	wire [15:0] tx_dlen = 16'(bidx) + 16'd1 - `ETFC_ETH_HDR;
	assign tx_in_ready = adv && !sim_rst &&
		(tx_st_r == TX_IDLE || tx_st_r == TX_DATA);
	assign tx_out_valid = out_v_r;
	assign tx_out = out_r;

	// framer sequence: data, optional pad, optional fcs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_st_r <= TX_IDLE;
			pos_r <= 11'h000;
			crc_r <= `ETFC_CRC_INIT;
			fcnt_r <= 2'd0;
			type_hi_r <= 8'h00;
			type_r <= 16'h0000;
			vlan_r <= 1'b0;
			out_v_r <= 1'b0;
			out_r <= '0;
		end else if (sim_rst) begin
			tx_st_r <= TX_IDLE;
			pos_r <= 11'h000;
			crc_r <= `ETFC_CRC_INIT;
			vlan_r <= 1'b0;
			out_v_r <= 1'b0;
		end else if (adv) begin
			case (tx_st_r)
				TX_IDLE, TX_DATA: begin
					out_v_r <= take;
					if (take) begin
						out_r.data <= tx_in.data;
						out_r.last <= tx_in.last && !need_pad && !fcs_en;
						pos_r <= pos_r + 11'd1;
						if (in_body) begin
							crc_r <= crc_step(crc_r, tx_in.data);
						end
						if (bidx == 11'd12 && in_body) begin
							type_hi_r <= tx_in.data;
						end
						if (bidx == 11'd13 && in_body) begin
							type_r <= {type_hi_r, tx_in.data};
							vlan_r <= vlan_now;
						end
						if (!tx_in.last) begin
							tx_st_r <= TX_DATA;
						end else if (need_pad) begin
							tx_st_r <= TX_PAD;
						end else if (fcs_en) begin
							tx_st_r <= TX_FCS;
							fcnt_r <= 2'd0;
						end else begin
							tx_st_r <= TX_IDLE;
							pos_r <= 11'h000;
							crc_r <= `ETFC_CRC_INIT;
							vlan_r <= 1'b0;
						end
					end
				end
				TX_PAD: begin
					// zero bytes up to the target, then fcs
					out_v_r <= 1'b1;
					out_r.data <= 8'h00;
					out_r.last <= 1'b0;
					crc_r <= crc_step(crc_r, 8'h00);
					pos_r <= pos_r + 11'd1;
					if ((bidx + 11'd1) >= pad_tgt) begin
						tx_st_r <= TX_FCS;
						fcnt_r <= 2'd0;
					end
				end
				TX_FCS: begin
					// fcs sent low byte first
					out_v_r <= 1'b1;
					out_r.data <= fcs[8*fcnt_r +: 8];
					out_r.last <= fcnt_r == 2'd3;
					fcnt_r <= fcnt_r + 2'd1;
					if (fcnt_r == 2'd3) begin
						tx_st_r <= TX_IDLE;
						pos_r <= 11'h000;
						crc_r <= `ETFC_CRC_INIT;
						vlan_r <= 1'b0;
					end
				end
				default: begin
					tx_st_r <= TX_IDLE;
					out_v_r <= 1'b0;
				end
			endcase
		end
	end

	// transmit events: starved mid-frame, forced underrun, bad length
	wire tx_und = (tx_st_r == TX_DATA && adv && !tx_in_valid) ||
		(test_r[`ETFC_T_FUND] && tx_st_r != TX_IDLE);
	wire tx_len = take && tx_in.last && cfg_r[`ETFC_C_LCHK] &&
		(bidx > 11'd13) && len_bad(type_r, tx_dlen);

	// receive pin synchroniser
	logic rxv_s1_r, rxv_s2_r; // valid stages
	etfc_byte_s rxb_s1_r, rxb_s2_r; // byte stages
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rxv_s1_r <= 1'b0;
			rxv_s2_r <= 1'b0;
			rxb_s1_r <= '0;
			rxb_s2_r <= '0;
		end else begin
			rxv_s1_r <= rx_pin_valid;
			rxv_s2_r <= rxv_s1_r;
			rxb_s1_r <= rx_pin;
			rxb_s2_r <= rxb_s1_r;
		end
	end

	// receive source: own transmit output in loopback
	wire src_v = loopback_enable ? fire : rxv_s2_r;
	etfc_byte_s src;
	assign src = loopback_enable ? tx_out : rxb_s2_r;
	logic rx_frame_r; // inside a frame
	logic rx_drop_r; // rest of frame discarded
	logic [15:0] rcnt_r; // bytes received
	logic [7:0] rtype_hi_r; // first length/type byte
	logic [15:0] rtype_r; // length/type field
	logic rov_r; // byte deliverable
	etfc_rxb_s rout_r; // byte towards fifo
	logic rev_r; // packet event
	wire [15:0] rbody = rcnt_r - 16'(hdr);
	wire ovr_now = (src_v && !rx_fifo_ready) ||
		test_r[`ETFC_T_FOVR];
	// discard a new frame while the overrun flag stands
	wire drop = rx_frame_r ? rx_drop_r : stat_r[`ETFC_S_ROVR];
	wire keep = src_v && !drop && !ovr_now && !sim_rst;
	wire rx_long = !cfg_r[`ETFC_C_UNB] &&
		(rcnt_r >= max_frame_length);
	wire rx_len = cfg_r[`ETFC_C_LCHK] && rbody > 16'd13 &&
		len_bad(rtype_r, rbody + 16'd1 - `ETFC_ETH_HDR - `ETFC_FCS_LEN);
	wire rx_end = keep && src.last;

	// receive frame tracking and delivery
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_frame_r <= 1'b0;
			rx_drop_r <= 1'b0;
			rcnt_r <= 16'h0000;
			rtype_hi_r <= 8'h00;
			rtype_r <= 16'h0000;
			rov_r <= 1'b0;
			rout_r <= '0;
			rev_r <= 1'b0;
		end else if (sim_rst) begin
			rx_frame_r <= 1'b0;
			rx_drop_r <= 1'b0;
			rcnt_r <= 16'h0000;
			rov_r <= 1'b0;
			rev_r <= 1'b0;
		end else begin
			rov_r <= keep;
			rev_r <= rx_end;
			if (src_v) begin
				rx_frame_r <= !src.last;
				rx_drop_r <= (drop || ovr_now) && !src.last;
				rcnt_r <= src.last ? 16'h0000 : rcnt_r + 16'd1;
				if (rbody == 16'd12) begin
					rtype_hi_r <= src.data;
				end
				if (rbody == 16'd13) begin
					rtype_r <= {rtype_hi_r, src.data};
				end
			end
			if (keep) begin
				rout_r.data <= src.data;
				rout_r.last <= src.last;
				rout_r.err <= src.last && (rx_long || rx_len);
			end
		end
	end

	assign rx_out_valid = rov_r;
	assign rx_out = rout_r;
	assign rx_packet_event = rev_r;
	// sticky event sources
	always_comb begin
		stat_set = 8'h00;
		stat_set[`ETFC_S_ROVR] = ovr_now && !sim_rst;
		stat_set[`ETFC_S_TUND] = tx_und && !sim_rst;
		stat_set[`ETFC_S_TLEN] = tx_len && !sim_rst;
		stat_set[`ETFC_S_RLEN] = rx_end && rx_len;
		stat_set[`ETFC_S_RLONG] = rx_end && rx_long;
	end

	// bytes sent in the current frame, for checks
	logic [10:0] ocnt_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ocnt_r <= 11'h000;
		end else if (sim_rst || (fire && tx_out.last)) begin
			ocnt_r <= 11'h000;
		end else if (fire) begin
			ocnt_r <= ocnt_r + 11'd1;
		end
	end

	rsv_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_pend_r && sel_test |=> hrdata[31:7] == 25'h0000000)
		else $error("reserved test bit read nonzero");
	unmapped_zero_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		rd_pend_r && !sel_test && !sel_cfg && !sel_stat |=> hrdata == 0)
		else $error("unmapped read not zero");
	duplex_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_r && sel_cfg |=> duplex_full == $past(hwdata[3]) &&
		csma_cd_enable == !$past(hwdata[3]))
		else $error("duplex mode not taken from write");
	sim_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		sim_rst |=> tx_st_r == TX_IDLE && !tx_out_valid && !rx_out_valid)
		else $error("simulation reset left datapath busy");
	loop_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
		loopback_enable && fire && !drop && !ovr_now && !sim_rst |=>
		rx_out_valid && rx_out.data == $past(tx_out.data))
		else $error("loopback byte not received");
	ovr_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
		stat_r[`ETFC_S_ROVR] && !rx_frame_r && src_v |=> !rx_out_valid)
		else $error("packet accepted during overrun");
	pad_min_a: assert property (@(posedge hclk) disable iff (!hresetn)
		fire && tx_out.last && pad_en && !cfg_r[6] && !cfg_r[5] |->
		ocnt_r + 11'd1 >= `ETFC_PAD_MIN + 11'd4 + hdr)
		else $error("padded frame under 64 bytes");
	pad_long_a: assert property (@(posedge hclk) disable iff (!hresetn)
		fire && tx_out.last && pad_en && !cfg_r[6] && cfg_r[5] |->
		ocnt_r + 11'd1 >= `ETFC_PAD_VLAN + 11'd4 + hdr)
		else $error("padded frame under 68 bytes");
	fcs_tail_a: assert property (@(posedge hclk) disable iff (!hresetn)
		adv && !sim_rst && tx_st_r == TX_FCS && fcnt_r == 2'd3 |=>
		tx_out_valid && tx_out.last && tx_st_r == TX_IDLE)
		else $error("fcs tail not ended with last");
	rx_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rx_out_valid && rx_out.last |-> rx_packet_event)
		else $error("packet end without receive event");
endmodule // etfc_top

// ==== dv/etfc_phy_model.sv ====
/*
 * line-side partner: takes transmit bytes with random stalls and tallies
 * frame lengths, and drives receive frames onto the phy pins.
 * assumes: one clock hclk; pins change just after its rising edge.
 */
module etfc_phy_model import etfc_pkg::*; (
	// clock
	input wire logic hclk,
	// transmit bytes from the mac
	input wire logic tx_out_valid,
	input wire etfc_byte_s tx_out,
	output logic tx_out_ready,
	// receive pins towards the mac
	output logic rx_pin_valid,
	output etfc_byte_s rx_pin,
	// tally for the bench
	output int n_tx_frames,
	output int tx_len
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed = 4947; // own stall pattern
	int cnt = 0; // bytes of the frame in flight
	// idle pins at time zero
	initial begin
		tx_out_ready = 1'b0;
		rx_pin_valid = 1'b0;
		rx_pin = '0;
		n_tx_frames = 0;
		tx_len = 0;
	end
	// count accepted bytes, stall one cycle in four on average
	always @(posedge hclk) begin
		if (tx_out_valid === 1'b1 && tx_out_ready === 1'b1) begin
			cnt = cnt + 1;
			if (tx_out.last === 1'b1) begin
				tx_len <= cnt;
				n_tx_frames <= n_tx_frames + 1;
				cnt = 0;
			end
		end
		tx_out_ready <= ($unsigned($random(seed)) % 4) != 0;
	end
	// one receive frame, type field 0800 so no length check applies
	task automatic send_rx(input int n);
		int i;
		@(posedge hclk);
		for (i = 0; i < n; i++) begin
			rx_pin_valid <= 1'b1;
			rx_pin.data <= (i == 12) ? 8'h08 :
				(i == 13) ? 8'h00 : 8'($random(seed));
			rx_pin.last <= (i == n - 1);
			@(posedge hclk);
		end
		// released pins show the inverse of the last byte
		rx_pin_valid <= 1'b0;
		rx_pin.data <= ~rx_pin.data;
	endtask
endmodule // etfc_phy_model

// ==== dv/tb.sv ====
/*
 * self-checking bench: ahb-lite master, transmit source, phy partner.
 * assumes: the design answers reads with one wait state.
 */
`include "etfc_map.svh"
module tb import etfc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] A_TEST = {22'h0, `ETFC_IDX_TEST, 2'b00};
	localparam logic [31:0] A_CFG = {22'h0, `ETFC_IDX_CFG1, 2'b00};
	localparam logic [31:0] A_STAT = {22'h0, `ETFC_IDX_STAT, 2'b00};
	// crc register after a good frame with its fcs, reflected form
	localparam logic [31:0] FCS_RES = 32'hDEBB20E3;
	// bench drives
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic tx_in_valid = 1'b0, rx_fifo_ready = 1'b1;
	etfc_byte_s tx_in = '0;
	logic [15:0] mfl = 16'h0014; // receive limit of 20 bytes
	// design and partner outputs
	logic hreadyout, hresp, tx_in_ready, tx_out_valid, tx_out_ready;
	logic [31:0] hrdata;
	etfc_byte_s tx_out, rx_pin;
	etfc_rxb_s rx_out;
	logic rx_pin_valid, rx_out_valid, rx_packet_event;
	logic ftm, fds, sst, sim, dfull, csma, lchk, unb;
	// bench state
	int seed = 4947, n_mismatch = 0, checks = 0, cyc = 0;
	int n_evt = 0, nb = 0, n_tx_frames, tx_len;
	logic last_err = 1'b0;
	logic [31:0] crc = '1, res = '0; // line fcs register and last residue
	int ob = 0, skip = 0; // line bytes of the frame, header bytes left out
	etfc_top etfc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .tx_in_valid(tx_in_valid),
		.tx_in(tx_in), .tx_in_ready(tx_in_ready),
		.tx_out_valid(tx_out_valid), .tx_out(tx_out),
		.tx_out_ready(tx_out_ready), .rx_pin_valid(rx_pin_valid),
		.rx_pin(rx_pin), .rx_out_valid(rx_out_valid), .rx_out(rx_out),
		.rx_fifo_ready(rx_fifo_ready), .rx_packet_event(rx_packet_event),
		.max_frame_length(mfl), .fifo_test_mode(ftm),
		.fifo_direction_select(fds), .slot_timer_shortcut(sst),
		.simulation_reset(sim), .duplex_full(dfull), .csma_cd_enable(csma),
		.length_field_check(lchk), .unbounded_frame_enable(unb));
	etfc_phy_model etfc_phy_model_inst (.hclk(hclk),
		.tx_out_valid(tx_out_valid), .tx_out(tx_out),
		.tx_out_ready(tx_out_ready), .rx_pin_valid(rx_pin_valid),
		.rx_pin(rx_pin), .n_tx_frames(n_tx_frames), .tx_len(tx_len));
	// clock of 20 ns
	always #10 hclk = ~hclk;
	// crc register after one byte, lsb first
	function automatic logic [31:0] crc8(input logic [31:0] c,
		input logic [7:0] d);
		c = c ^ {24'h0, d};
		for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
		return c;
	endfunction
	// event, receive byte and line fcs tallies, then timeout
	always @(posedge hclk) begin
		cyc++;
		if (rx_packet_event === 1'b1) n_evt++;
		if (rx_out_valid === 1'b1) begin
			nb++;
			if (rx_out.last === 1'b1) last_err = rx_out.err;
		end
		if (tx_out_valid === 1'b1 && tx_out_ready === 1'b1) begin
			if (ob >= skip) crc = crc8(crc, tx_out.data);
			ob++;
			if (tx_out.last === 1'b1) begin
				res = crc;
				crc = '1;
				ob = 0;
			end
		end
		if (cyc == 60000) begin
			n_mismatch++;
			results();
		end
	end
	// compare and report
	task automatic chk(input string nm, input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one single ahb-lite transfer, waits on hready in both phases
	task automatic ahb(input logic w, input logic [31:0] a, d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask
	// send one transmit frame, tagged or not
	task automatic send_tx(input int n, input logic vl);
		int i;
		@(posedge hclk);
		for (i = 0; i < n; i++) begin
			tx_in_valid <= 1'b1;
			tx_in.data <= (i == 12) ? (vl ? 8'h81 : 8'h08) :
				(i == 13) ? 8'h00 : 8'($random(seed));
			tx_in.last <= (i == n - 1);
			do @(posedge hclk); while (tx_in_ready !== 1'b1);
		end
		tx_in_valid <= 1'b0;
	endtask
	// wait for the partner to see one more frame
	task automatic wait_tx(input int f0);
		int k;
		for (k = 0; k < 600 && n_tx_frames == f0; k++) @(posedge hclk);
	endtask
	// frame length on the line for a config byte
	function automatic int exp_len(input logic [7:0] c, input int n,
		input logic vl);
		int m;
		if (!c[7]) return n + (c[4] ? 4 : 0);
		m = (c[6] ? vl : c[5]) ? 64 : 60;
		return ((n > m) ? n : m) + 4;
	endfunction
	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// main sequence
	initial begin
		logic [31:0] q;
		logic [7:0] v, c;
		int i, n, e0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, A_TEST, 0, q);
		chk("test reset", q, {24'h0, `ETFC_TEST_RST});
		ahb(1'b0, A_CFG, 0, q);
		chk("cfg reset", q, {24'h0, `ETFC_CFG1_RST});
		chk("csma reset", csma, 1);
		$display("done reset values");
		// random register values; first pass sets the reserved bit
		for (i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			wr(A_TEST, {24'h0, (i == 0) ? (v | 8'h80) : (v & 8'h7F)});
			ahb(1'b0, A_TEST, 0, q);
			chk("test read", q, {24'h0, v & 8'h7F});
			chk("fifo mode", ftm, v[6]);
			chk("fifo dir", fds, v[5]);
			chk("slot short", sst, v[4]);
			chk("sim reset", sim, v[3]);
			wr(A_CFG, {24'h0, v});
			ahb(1'b0, A_CFG, 0, q);
			chk("cfg read", q, {24'h0, v});
			chk("duplex", dfull, v[3]);
			chk("csma", csma, !v[3]);
			chk("len check", lchk, v[2]);
			chk("unbounded", unb, v[1]);
		end
		// simulation reset holds the framer
		wr(A_TEST, 32'h08);
		@(posedge hclk);
		#1 chk("tx ready", tx_in_ready, 0);
		wr(A_TEST, 32'h00);
		wr(A_STAT, 32'h1F);
		wr(32'h88, 32'hFF);
		ahb(1'b0, 32'h88, 0, q);
		chk("unmapped", q, 0);
		chk("unmapped resp", hresp, 0);
		$display("done registers");
		// every pad and fcs setting, tagged and untagged
		for (i = 0; i < 32; i++) begin
			c = {i[3:0], 4'h0};
			n = (i % 4 == 0) ? 60 : (i % 4 == 1) ? 64 :
				14 + $unsigned($random(seed)) % 60;
			wr(A_CFG, {24'h0, c});
			e0 = n_tx_frames;
			send_tx(n, i[4]);
			wait_tx(e0);
			chk("tx length", tx_len, exp_len(c, n, i[4]));
			if (c[7] || c[4]) chk("tx fcs", res, FCS_RES);
		end
		// header left out of the fcs, forced underrun flagged meanwhile
		wr(A_CFG, 32'h11);
		wr(A_TEST, 32'h02);
		skip = 4;
		e0 = n_tx_frames;
		send_tx(30, 1'b0);
		wait_tx(e0);
		chk("hdr length", tx_len, 34);
		chk("hdr fcs", res, FCS_RES);
		ahb(1'b0, A_STAT, 0, q);
		chk("underrun flag", q[1], 1);
		wr(A_TEST, 32'h00);
		wr(A_STAT, 32'h02);
		skip = 0;
		$display("done transmit framing");
		// loopback carries the frame into the receive side
		wr(A_CFG, 32'h00);
		wr(A_TEST, 32'h01);
		nb = 0;
		e0 = n_evt;
		send_tx(30, 1'b0);
		wait_tx(n_tx_frames);
		repeat (6) @(posedge hclk);
		chk("loop bytes", nb, 30);
		chk("loop event", n_evt, e0 + 1);
		wr(A_TEST, 32'h00);
		e0 = n_evt;
		etfc_phy_model_inst.send_rx(30);
		repeat (8) @(posedge hclk);
		chk("rx event", n_evt, e0 + 1);
		$display("done loopback and receive");
		// receive size limit, then unlimited
		etfc_phy_model_inst.send_rx(40);
		repeat (8) @(posedge hclk);
		chk("too long", last_err, 1);
		wr(A_CFG, 32'h02);
		etfc_phy_model_inst.send_rx(40);
		repeat (8) @(posedge hclk);
		chk("unlimited", last_err, 0);
		// forced overrun drops frames until the flag clears
		wr(A_TEST, 32'h04);
		wr(A_TEST, 32'h00);
		ahb(1'b0, A_STAT, 0, q);
		chk("overrun flag", q[0], 1);
		e0 = n_evt;
		etfc_phy_model_inst.send_rx(30);
		repeat (8) @(posedge hclk);
		chk("dropped", n_evt, e0);
		wr(A_STAT, 32'h01);
		etfc_phy_model_inst.send_rx(30);
		repeat (8) @(posedge hclk);
		chk("after clear", n_evt, e0 + 1);
		$display("done overrun");
		// reset in mid-run restores defaults
		wr(A_TEST, 32'h31);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, A_TEST, 0, q);
		chk("test reset 2", q, {24'h0, `ETFC_TEST_RST});
		ahb(1'b0, A_CFG, 0, q);
		chk("cfg reset 2", q, {24'h0, `ETFC_CFG1_RST});
		$display("done mid-run reset");
		results();
	end
endmodule // tb
